// ===== inc/vpto_cfg.svh
// constants for the voice port test override
`ifndef VPTO_CFG_SVH
`define VPTO_CFG_SVH
`define CORE_CLK_HZ 100000000
`define SIGMON_WINDOW_S 4
`define SIGMON_LIMIT 255
`define SAMPLE_HZ 8000
`define TONE_300_HZ 300
`define TONE_1K_HZ 1000
`define TONE_3K_HZ 3000
`define ULAW_SILENCE 8'hff
`define TONE_MAG {7'h14, 7'h16, 7'h1c, 7'h27, 7'h7f}
`define TC_ABCD 4'hf
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ISTS 8'h08
`define REG_ICLR 8'h0c
`define REG_IEN 8'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define EV_ALARM 0
`define EV_TC 1
`define EV_W 2
`endif

// ===== inc/vpto_pkg.sv
// types for the voice port test override
package vpto_pkg;
    typedef enum logic [2:0] {INJ_PCM, INJ_300, INJ_1K, INJ_3K, INJ_QUIET,
        INJ_NA} vpto_inj_e;
    typedef enum logic [2:0] {LL_LOOP, LL_OPEN, LL_RGND, LL_LPGND,
        LL_RING} vpto_local_e;
    typedef enum logic [3:0] {FL_RING, FL_TBRG, FL_TORO, FL_TGRO, FL_RBTG,
        FL_RBTO, FL_TGRX, FL_TORX, FL_ROTX, FL_NA} vpto_far_e;
    typedef enum logic [1:0] {PM_FXO, PM_FXODN, PM_DPT, PM_MRD} vpto_mode_e;
    typedef enum logic [2:0] {ST_LOOP, ST_GS, ST_LPFD, ST_R2, ST_DPT, ST_IR2,
        ST_MRD} vpto_sig_e;
    typedef enum logic [3:0] {PS_STDBY, PS_WSTB, PS_WTST, PS_WOOS, PS_NO_WAN_CARD,
        PS_CALL, PS_BUSY, PS_IDLE, PS_TC, PS_TEST, PS_MAINT} vpto_pstat_e;
    typedef enum logic [2:0] {WAN_ACTIVE, WAN_STDBY, WAN_TEST, WAN_OOS,
        WAN_NONE} vpto_wan_e;
    typedef enum logic [1:0] {CALL_IDLE, CALL_SETUP, CALL_BUSY} vpto_call_e;
    typedef struct packed {
        logic [13:0] rsvd;
        logic [3:0] rxPattern;
        logic [3:0] txPattern;
        logic [2:0] ntwkInj;
        logic [2:0] userInj;
        logic rxSet;
        logic txSet;
        logic testEn;
        logic sigMonEn;
    } vpto_ctrl_s;
    typedef struct packed {
        logic [3:0] rsvd;
        vpto_inj_e ntwkInj;
        vpto_inj_e userInj;
        vpto_pstat_e portStatus;
        vpto_sig_e sigType;
        vpto_far_e farLead;
        vpto_local_e localLead;
        logic [3:0] rxAbcd;
        logic [3:0] txAbcd;
    } vpto_stat_s;
    typedef struct packed {
        logic portActive;
        logic maintMode;
        logic busConnect;
        vpto_wan_e wanState;
        vpto_call_e callState;
        vpto_mode_e portMode;
        logic [1:0] sigTypeSel;
        logic [2:0] localLead;
        logic [3:0] farLead;
    } vpto_cond_s;
endpackage

// ===== logic/vpto_top.sv
// voice port test override with axi4-lite registers
`include "vpto_cfg.svh"
module vpto_top #(
    parameter int unsigned WINDOW_CYCLES = `SIGMON_WINDOW_S * `CORE_CLK_HZ,
    parameter int unsigned LIMIT = `SIGMON_LIMIT
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic sampleStb,
    input wire logic [7:0] netVoiceIn,
    input wire logic [7:0] userVoiceIn,
    output logic [7:0] netVoiceOut,
    output logic [7:0] userVoiceOut,
    input wire logic [3:0] lineAbcdIn,
    input wire logic [3:0] netAbcdIn,
    output logic [3:0] netAbcdOut,
    output logic [3:0] lineAbcdOut,
    input wire vpto_pkg::vpto_cond_s cond,
    input wire logic carrierGroupAlarm,
    output logic trunkCondition,
    output logic irq
);
    localparam int CNT_W = $clog2(LIMIT + 2);
    localparam logic [34:0] TONE_MAG = `TONE_MAG;
    localparam logic [31:0] WIN_LAST = 32'(WINDOW_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_LIM = CNT_W'(LIMIT);

    if (WINDOW_CYCLES < 2 || LIMIT < 1 || LIMIT > 65535) begin : g_chk
        $error("vpto_top: window or limit out of range");
    end

    function automatic logic [15:0] toneStep(vpto_pkg::vpto_inj_e s);
        unique case (s)
            vpto_pkg::INJ_300:
                toneStep = 16'((`TONE_300_HZ * 65536) / `SAMPLE_HZ);
            vpto_pkg::INJ_1K:
                toneStep = 16'((`TONE_1K_HZ * 65536) / `SAMPLE_HZ);
            vpto_pkg::INJ_3K:
                toneStep = 16'((`TONE_3K_HZ * 65536) / `SAMPLE_HZ);
            default: toneStep = 16'h0000;
        endcase
    endfunction

    // one sine period in sixteen steps from a five-entry quarter table
    function automatic logic [7:0] toneCode(logic [15:0] ph);
        logic [1:0] k;
        logic [2:0] n;
        k = ph[13:12];
        n = ph[14] ? 3'(3'd4 - {1'b0, k}) : {1'b0, k};
        toneCode = {~ph[15], TONE_MAG[n*7 +: 7]};
    endfunction

    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
        logic [3:0] s);
        merge = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                merge[b*8 +: 8] = n[b*8 +: 8];
            end
        end
    endfunction

    // carrier group alarm pin, three-stage synchroniser
    logic [2:0] cgaSync_q;
    logic cgaLevel_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cgaSync_q <= 3'h0;
            cgaLevel_q <= 1'b0;
        end else begin
            cgaSync_q <= {cgaSync_q[1:0], carrierGroupAlarm};
            if (cgaSync_q[1] == cgaSync_q[2]) begin
                cgaLevel_q <= cgaSync_q[2];
            end
        end
    end

    vpto_pkg::vpto_ctrl_s ctrl_q, ctrl_d;
    logic [`EV_W-1:0] ien_q, ien_d, ists_q, ists_d, ev;
    logic tc, ovrActive, rxSetOk, irq_d;
    vpto_pkg::vpto_inj_e sel [2];
    vpto_pkg::vpto_stat_s stat;

    assign tc = cgaLevel_q && cond.portActive;
    assign rxSetOk = ctrl_q.rxSet && !cond.busConnect;
    assign ovrActive = ctrl_q.testEn && (ctrl_q.txSet || rxSetOk);

    // injection selections; bus-connect chassis never injects
    always_comb begin
        for (int d = 0; d < 2; d++) begin
            sel[d] = vpto_pkg::INJ_PCM;
        end
        if (ctrl_q.testEn && !cond.busConnect) begin
            if (ctrl_q.userInj <= 3'(vpto_pkg::INJ_QUIET)) begin
                sel[0] = vpto_pkg::vpto_inj_e'(ctrl_q.userInj);
            end
            if (ctrl_q.ntwkInj <= 3'(vpto_pkg::INJ_QUIET)) begin
                sel[1] = vpto_pkg::vpto_inj_e'(ctrl_q.ntwkInj);
            end
        end
    end

    // voice path: dir 0 toward user, dir 1 toward network
    logic [7:0] vIn [2];
    logic [7:0] vOut_q [2];
    assign vIn[0] = netVoiceIn;
    assign vIn[1] = userVoiceIn;
    assign userVoiceOut = vOut_q[0];
    assign netVoiceOut = vOut_q[1];
    for (genvar d = 0; d < 2; d++) begin : g_dir
        logic [15:0] ph_q, ph_d;
        logic [7:0] v_d;
        always_comb begin
            ph_d = ph_q;
            v_d = vOut_q[d];
            // only the slot strobe moves the path, so timing is untouched
            if (sampleStb) begin
                ph_d = ph_q + toneStep(sel[d]);
                unique case (sel[d])
                    vpto_pkg::INJ_PCM: v_d = vIn[d];
                    vpto_pkg::INJ_QUIET: v_d = `ULAW_SILENCE;
                    default: v_d = toneCode(ph_q);
                endcase
                if (d == 0 && tc) begin
                    v_d = `ULAW_SILENCE;
                end
            end
        end
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                ph_q <= 16'h0000;
                vOut_q[d] <= `ULAW_SILENCE;
            end else begin
                ph_q <= ph_d;
                vOut_q[d] <= v_d;
            end
        end
    end

    // signalling override; lead control has no forcing path at all
    logic [3:0] txAbcd_d, rxAbcd_d;
    always_comb begin
        txAbcd_d = lineAbcdIn;
        rxAbcd_d = netAbcdIn;
        if (ctrl_q.testEn && ctrl_q.txSet) begin
            txAbcd_d = ctrl_q.txPattern;
        end
        if (tc) begin
            rxAbcd_d = `TC_ABCD;
        end else if (ctrl_q.testEn && rxSetOk) begin
            rxAbcd_d = ctrl_q.rxPattern;
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            netAbcdOut <= 4'h0;
            lineAbcdOut <= 4'h0;
            trunkCondition <= 1'b0;
        end else begin
            netAbcdOut <= txAbcd_d;
            lineAbcdOut <= rxAbcd_d;
            trunkCondition <= tc;
        end
    end

    // transition monitor over both directions, counters clear per window
    logic [7:0] prev_q, hit;
    logic [31:0] win_q, win_d;
    logic monEn, winEnd;
    assign monEn = ctrl_q.sigMonEn && cond.portActive;
    assign winEnd = win_q == WIN_LAST;
    always_comb begin
        win_d = (!monEn || winEnd) ? 32'h0 : win_q + 32'h1;
    end
    for (genvar i = 0; i < 8; i++) begin : g_mon
        logic [CNT_W-1:0] cnt_q, cnt_d;
        logic cur;
        assign cur = i < 4 ? netAbcdOut[i%4] : lineAbcdOut[i%4];
        assign hit[i] = monEn && !winEnd && cur != prev_q[i] &&
            cnt_q == CNT_LIM;
        always_comb begin
            cnt_d = cnt_q;
            if (!monEn || winEnd) begin
                cnt_d = '0;
            end else if (cur != prev_q[i] && cnt_q <= CNT_LIM) begin
                cnt_d = cnt_q + 1'b1;
            end
        end
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                cnt_q <= '0;
                prev_q[i] <= 1'b0;
            end else begin
                cnt_q <= cnt_d;
                prev_q[i] <= cur;
            end
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            win_q <= 32'h0;
        end else begin
            win_q <= win_d;
        end
    end

    // status word
    logic tcPrev_q;
    always_comb begin
        stat = '0;
        stat.txAbcd = netAbcdOut;
        stat.rxAbcd = lineAbcdOut;
        stat.localLead = cond.localLead > 3'(vpto_pkg::LL_RING) ?
            vpto_pkg::LL_OPEN : vpto_pkg::vpto_local_e'(cond.localLead);
        stat.farLead = cond.farLead > 4'(vpto_pkg::FL_NA) ?
            vpto_pkg::FL_NA : vpto_pkg::vpto_far_e'(cond.farLead);
        unique case (cond.portMode)
            vpto_pkg::PM_MRD: stat.sigType = vpto_pkg::ST_MRD;
            vpto_pkg::PM_DPT: stat.sigType = cond.sigTypeSel == 2'h1 ?
                vpto_pkg::ST_R2 : cond.sigTypeSel == 2'h2 ?
                vpto_pkg::ST_IR2 : vpto_pkg::ST_DPT;
            default: stat.sigType = vpto_pkg::vpto_sig_e'(cond.sigTypeSel);
        endcase
        // test outranks trunk conditioning so an operator sees his override
        if (!cond.portActive) begin
            stat.portStatus = vpto_pkg::PS_STDBY;
        end else if (cond.wanState == vpto_pkg::WAN_NONE) begin
            stat.portStatus = vpto_pkg::PS_NO_WAN_CARD;
        end else if (cond.wanState == vpto_pkg::WAN_STDBY) begin
            stat.portStatus = vpto_pkg::PS_WSTB;
        end else if (cond.wanState == vpto_pkg::WAN_TEST) begin
            stat.portStatus = vpto_pkg::PS_WTST;
        end else if (cond.wanState == vpto_pkg::WAN_OOS) begin
            stat.portStatus = vpto_pkg::PS_WOOS;
        end else if (cond.maintMode) begin
            stat.portStatus = vpto_pkg::PS_MAINT;
        end else if (ovrActive) begin
            stat.portStatus = vpto_pkg::PS_TEST;
        end else if (tc) begin
            stat.portStatus = vpto_pkg::PS_TC;
        end else if (cond.callState == vpto_pkg::CALL_SETUP) begin
            stat.portStatus = vpto_pkg::PS_CALL;
        end else if (cond.callState == vpto_pkg::CALL_BUSY) begin
            stat.portStatus = vpto_pkg::PS_BUSY;
        end else begin
            stat.portStatus = vpto_pkg::PS_IDLE;
        end
        stat.userInj = cond.busConnect ? vpto_pkg::INJ_NA : sel[0];
        stat.ntwkInj = cond.busConnect ? vpto_pkg::INJ_NA : sel[1];
    end
    assign ev[`EV_ALARM] = |hit;
    assign ev[`EV_TC] = tc && !tcPrev_q;

    // axi4-lite slave, one write and one read at a time
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bv_d, awr_d, wr_d;
    logic rv_d, arr_d;
    logic [7:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d, rdata_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bresp_d, rresp_d;
    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bv_d = s_axi_bvalid && !s_axi_bready;
        bresp_d = s_axi_bresp;
        ctrl_d = ctrl_q;
        ien_d = ien_q;
        ists_d = ists_q;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (awHeld_q && wHeld_q && !s_axi_bvalid) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bv_d = 1'b1;
            bresp_d = `RESP_OKAY;
            unique case (awAddr_q)
                `REG_CTRL: ctrl_d = merge(ctrl_q, wData_q, wStrb_q);
                `REG_IEN: ien_d = `EV_W'(merge(32'(ien_q), wData_q, wStrb_q));
                `REG_ICLR: ists_d = ists_q & ~`EV_W'(wData_q & {8{wStrb_q[0]}});
                `REG_STATUS, `REG_ISTS: ;
                default: bresp_d = `RESP_SLVERR;
            endcase
        end
        ctrl_d.rsvd = '0;
        ists_d = ists_d | ev;                 // a new event beats the clear
        awr_d = !awHeld_d && !bv_d;
        wr_d = !wHeld_d && !bv_d;
        irq_d = |(ists_q & ien_q);
    end
    always_comb begin
        rv_d = s_axi_rvalid && !s_axi_rready;
        rdata_d = s_axi_rdata;
        rresp_d = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rresp_d = `RESP_OKAY;
            unique case (s_axi_araddr)
                `REG_CTRL: rdata_d = ctrl_q;
                `REG_STATUS: rdata_d = stat;
                `REG_ISTS: rdata_d = 32'(ists_q);
                `REG_IEN: rdata_d = 32'(ien_q);
                `REG_ICLR: rdata_d = 32'h0;
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = `RESP_SLVERR;
                end
            endcase
        end
        arr_d = !rv_d;
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            ctrl_q <= '0;
            ien_q <= '0;
            ists_q <= '0;
            irq <= 1'b0;
            tcPrev_q <= 1'b0;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            s_axi_bvalid <= bv_d;
            s_axi_bresp <= bresp_d;
            s_axi_awready <= awr_d;
            s_axi_wready <= wr_d;
            s_axi_rvalid <= rv_d;
            s_axi_rdata <= rdata_d;
            s_axi_rresp <= rresp_d;
            s_axi_arready <= arr_d;
            ctrl_q <= ctrl_d;
            ien_q <= ien_d;
            ists_q <= ists_d;
            irq <= irq_d;
            tcPrev_q <= tc;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    tx_set_drive_a: assert property (ctrl_q.testEn && ctrl_q.txSet |=>
        netAbcdOut == $past(ctrl_q.txPattern)) else $error("tx pattern");
    rx_set_drive_a: assert property (ctrl_q.testEn && rxSetOk && !tc |=>
        lineAbcdOut == $past(ctrl_q.rxPattern)) else $error("rx pattern");
    user_pcm_pass_a: assert property (sampleStb && !tc &&
        sel[0] == vpto_pkg::INJ_PCM |=> userVoiceOut == $past(netVoiceIn))
        else $error("user path altered");
    net_pcm_pass_a: assert property (sampleStb &&
        sel[1] == vpto_pkg::INJ_PCM |=> netVoiceOut == $past(userVoiceIn))
        else $error("network path altered");
    bus_no_inject_a: assert property (cond.busConnect |->
        sel[1] == vpto_pkg::INJ_PCM && stat.userInj == vpto_pkg::INJ_NA)
        else $error("injection in bus-connect");
    quiet_user_a: assert property (sampleStb &&
        sel[0] == vpto_pkg::INJ_QUIET |=> userVoiceOut == `ULAW_SILENCE)
        else $error("user silence missing");
    test_status_a: assert property (ovrActive && cond.portActive &&
        cond.wanState == vpto_pkg::WAN_ACTIVE && !cond.maintMode |->
        stat.portStatus == vpto_pkg::PS_TEST) else $error("test status");
    tc_apply_a: assert property ($rose(cgaLevel_q) && cond.portActive
        |=> trunkCondition && lineAbcdOut == `TC_ABCD) else $error("no tc");
    sig_alarm_a: assert property (|hit |=> ists_q[`EV_ALARM] ##1
        (irq || !$past(ien_q[`EV_ALARM]))) else $error("alarm lost");
    mrd_type_a: assert property (cond.portMode == vpto_pkg::PM_MRD |->
        stat.sigType == vpto_pkg::ST_MRD) else $error("ringdown type");
    tone_c: cover property (sampleStb && sel[1] == vpto_pkg::INJ_1K);
    alarm_c: cover property (|hit);
    tc_c: cover property ($rose(trunkCondition));
endmodule

// ===== verification/vpto_far_model.sv
// far side model: wan slot stream and line signalling
module vpto_far_model (
    input wire logic core_clk,
    input wire logic toggle,
    output logic sampleStb,
    output logic [7:0] netVoiceIn,
    output logic [7:0] userVoiceIn,
    output logic [3:0] lineAbcdIn,
    output logic [3:0] netAbcdIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    initial begin
        sampleStb = 1'h0;
        netVoiceIn = 8'h00;
        userVoiceIn = 8'h00;
        lineAbcdIn = 4'h0;
        netAbcdIn = 4'h0;
    end
    // one strobe per 16 cycles keeps slot timing regular
    always @(posedge core_clk) begin
        cnt <= cnt + 4'h1;
        sampleStb <= (cnt == 4'he);
        if (sampleStb) begin
            netVoiceIn <= 8'($urandom);
            userVoiceIn <= 8'($urandom);
        end
        // random signalling would spoil the transition count, so hold it
        if (toggle) begin
            lineAbcdIn[0] <= ~lineAbcdIn[0];
        end else if (sampleStb) begin
            lineAbcdIn <= 4'($urandom);
            netAbcdIn <= 4'($urandom);
        end
    end
endmodule

// ===== verification/testbench.sv
// self-checking bench for the voice port test override
`include "vpto_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0, nrst = 1'h0, toggle = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, carrierGroupAlarm = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb = 4'h0, lineAbcdIn, netAbcdIn, netAbcdOut;
    logic [3:0] lineAbcdOut, txP = 4'h0, rxP = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, sampleStb, trunkCondition, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0] netVoiceIn, userVoiceIn, netVoiceOut, userVoiceOut, eu, en;
    logic monOn = 1'h0, pend = 1'h0, txS = 1'h0, rxS = 1'h0;
    logic [2:0] uI = 3'h0, nI = 3'h0;
    vpto_pkg::vpto_cond_s cond = '0, c;
    vpto_pkg::vpto_ctrl_s k;
    vpto_pkg::vpto_stat_s s;
    logic [2:0] el;
    logic [3:0] ef;
    int nMismatch = 0, numChecks = 0, cyc = 0;
    // short window keeps the transition monitor test brief
    vpto_top #(.WINDOW_CYCLES(4000)) uut (.*);
    vpto_far_model far (.*);
    always #5 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] g, e, input string m);
        numChecks++;
        if (g !== e) begin
            nMismatch++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic endSim();
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awvalid <= 1'h1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        // address and data may be taken on different edges
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid
            && !s_axi_wready);
        s_axi_bready <= 1'h1;
        do @(posedge core_clk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr <= a;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do @(posedge core_clk); while (!s_axi_rvalid);
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge core_clk);
    endtask
    function automatic logic [7:0] vox(logic [2:0] inj, logic [7:0] v);
        return (inj == 3'h4) ? `ULAW_SILENCE : v;
    endfunction
    function automatic vpto_pkg::vpto_sig_e sig(vpto_pkg::vpto_mode_e m,
        logic [1:0] t);
        if (m == vpto_pkg::PM_MRD) return vpto_pkg::ST_MRD;
        if (m != vpto_pkg::PM_DPT) return vpto_pkg::vpto_sig_e'({1'h0, t});
        if (t == 2'h1) return vpto_pkg::ST_R2;
        return (t == 2'h2) ? vpto_pkg::ST_IR2 : vpto_pkg::ST_DPT;
    endfunction
    // status priority: standby, wan states, maintenance, then call state
    function automatic vpto_pkg::vpto_pstat_e pst(vpto_pkg::vpto_cond_s q);
        if (!q.portActive) return vpto_pkg::PS_STDBY;
        if (q.wanState == vpto_pkg::WAN_NONE) return vpto_pkg::PS_NO_WAN_CARD;
        if (q.wanState == vpto_pkg::WAN_STDBY) return vpto_pkg::PS_WSTB;
        if (q.wanState == vpto_pkg::WAN_TEST) return vpto_pkg::PS_WTST;
        if (q.wanState == vpto_pkg::WAN_OOS) return vpto_pkg::PS_WOOS;
        if (q.maintMode) return vpto_pkg::PS_MAINT;
        if (q.callState == vpto_pkg::CALL_SETUP) return vpto_pkg::PS_CALL;
        if (q.callState == vpto_pkg::CALL_BUSY) return vpto_pkg::PS_BUSY;
        return vpto_pkg::PS_IDLE;
    endfunction
    task automatic setk(input logic [2:0] inj, input logic ts, rs);
        monOn = 1'h0;
        pend = 1'h0;
        k = '0;
        k.testEn = 1'h1;
        k.userInj = inj;
        k.ntwkInj = inj;
        k.txSet = ts;
        k.rxSet = rs;
        k.txPattern = 4'($urandom);
        k.rxPattern = 4'($urandom);
        wr(`REG_CTRL, k);
        txS = ts;
        rxS = rs && !cond.busConnect;
        txP = k.txPattern;
        rxP = k.rxPattern;
        uI = cond.busConnect ? 3'h0 : inj;
        nI = uI;
        repeat (4) @(posedge core_clk);
    endtask
    // settled samples are checked on the falling edge
    always @(negedge core_clk) begin
        if (pend) begin
            chk(userVoiceOut, eu, "user voice");
            chk(netVoiceOut, en, "net voice");
        end
        pend = monOn && sampleStb;
        if (pend) begin
            eu = vox(uI, netVoiceIn);
            en = vox(nI, userVoiceIn);
            chk(netAbcdOut, txS ? txP : lineAbcdIn, "outbound_signalling_pattern");
            chk(lineAbcdOut, rxS ? rxP : netAbcdIn, "inbound_signalling_pattern");
        end
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 50000) begin
            nMismatch++;
            endSim();
        end
    end
    initial begin
        void'($urandom(32'h9495));
        repeat (20) @(posedge core_clk);
        nrst <= 1'h1;
        @(posedge core_clk);
        rd(`REG_CTRL);
        chk(rdv, 32'h0, "ctrl reset");
        rd(8'h40);
        chk(rsp, `RESP_SLVERR, "unmapped");
        wr(8'h40, 32'h0);
        chk(rsp, `RESP_SLVERR, "unmapped write");
        wr(`REG_STATUS, 32'hffffffff);
        chk(rsp, `RESP_OKAY, "read-only write");
        for (int i = 0; i < 24; i++) begin
            c = '0;
            c.portActive = ($urandom_range(7) != 0);
            c.maintMode = ($urandom_range(7) == 0);
            c.wanState = vpto_pkg::vpto_wan_e'(3'($urandom_range(4)));
            c.callState = vpto_pkg::vpto_call_e'(2'($urandom_range(2)));
            c.portMode = vpto_pkg::vpto_mode_e'(2'($urandom));
            c.sigTypeSel = 2'($urandom);
            c.localLead = 3'($urandom);
            c.farLead = 4'($urandom);
            // codes past the last legal one read open and not available
            el = c.localLead > 3'(vpto_pkg::LL_RING) ?
                3'(vpto_pkg::LL_OPEN) : c.localLead;
            ef = c.farLead > 4'(vpto_pkg::FL_NA) ?
                4'(vpto_pkg::FL_NA) : c.farLead;
            cond <= c;
            repeat (2) @(posedge core_clk);
            rd(`REG_STATUS);
            s = vpto_pkg::vpto_stat_s'(rdv);
            chk(s.localLead, el, "local lead");
            chk(s.farLead, ef, "far lead");
            chk(s.sigType, sig(c.portMode, c.sigTypeSel), "type");
            chk(s.portStatus, pst(c), "status");
        end
        cond.portActive <= 1'h1;
        cond.wanState <= vpto_pkg::WAN_ACTIVE;
        cond.maintMode <= 1'h0;
        monOn = 1'h1;
        repeat (60) @(posedge core_clk);
        for (int b = 0; b < 2; b++) begin
            cond.busConnect <= b[0];
            for (int j = 1; j < 5; j++) begin
                setk(3'(j), 1'h1, 1'h1);
                monOn = (j == 4);
                repeat (40) @(posedge core_clk);
                rd(`REG_STATUS);
                s = vpto_pkg::vpto_stat_s'(rdv);
                chk(s.userInj, b ? 3'h5 : 3'(j), "user inj");
                chk(s.ntwkInj, b ? 3'h5 : 3'(j), "ntwk inj");
                chk(s.portStatus, vpto_pkg::PS_TEST, "test");
            end
        end
        cond.busConnect <= 1'h0;
        setk(3'h0, 1'h0, 1'h0);
        wr(`REG_CTRL, 32'h0);
        wr(`REG_IEN, 32'h3);
        carrierGroupAlarm <= 1'h1;
        repeat (40) @(posedge core_clk);
        chk({trunkCondition, irq, lineAbcdOut}, 6'h3f, "tc");
        chk(userVoiceOut, `ULAW_SILENCE, "tc voice");
        rd(`REG_STATUS);
        chk(rdv[21:18], vpto_pkg::PS_TC, "tc status");
        carrierGroupAlarm <= 1'h0;
        repeat (10) @(posedge core_clk);
        wr(`REG_ICLR, 32'h2);
        rd(`REG_ISTS);
        chk(rdv, 32'h0, "cleared");
        chk(irq, 1'h0, "irq cleared");
        wr(`REG_CTRL, 32'h1);
        toggle <= 1'h1;
        repeat (250) @(posedge core_clk);
        rd(`REG_ISTS);
        chk(rdv, 32'h0, "below limit");
        repeat (10) @(posedge core_clk);
        toggle <= 1'h0;
        rd(`REG_ISTS);
        chk(rdv, 32'h1, "alarm");
        chk(irq, 1'h1, "alarm irq");
        wr(`REG_IEN, 32'h0);
        chk(irq, 1'h0, "masked");
        endSim();
    end
endmodule
